/* src/io_window_pkg.sv */
// constants for the pc card i/o window configuration block
package io_window_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets in the legacy socket register space
  localparam logic [7:0] OFF_WINDOW_ENABLE  = 8'h06;
  localparam logic [7:0] OFF_CYCLE_CONTROL  = 8'h07;
  localparam logic [7:0] OFF_WIN0_START_LOW = 8'h08;
  localparam logic [7:0] OFF_WIN0_START_HI  = 8'h09;
  localparam logic [7:0] OFF_WIN0_END_LOW   = 8'h0a;
  localparam logic [7:0] OFF_WIN0_END_HI    = 8'h0b;
  localparam logic [7:0] OFF_WIN1_START_LOW = 8'h0c;
  localparam logic [7:0] OFF_WIN1_START_HI  = 8'h0d;
  localparam logic [7:0] OFF_WIN1_END_LOW   = 8'h0e;
  localparam logic [7:0] OFF_WIN1_END_HI    = 8'h0f;
  localparam int         REG_COUNT          = 10;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_WINDOW_ENABLE  = 8'h00;
  localparam logic [7:0] RST_CYCLE_CONTROL  = 8'h00;
  localparam logic [7:0] RST_ADDR_BYTE      = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int POS_IO_WINDOW_ONE_ON   = 7;
  localparam int POS_IO_WINDOW_ZERO_ON  = 6;
  localparam int POS_ENABLE_RSVD        = 5;
  localparam int POS_WIN1_EXTRA_WAIT    = 7;
  localparam int POS_WIN1_SHORT_BYTE    = 6;
  localparam int POS_WIN1_AUTO_SIZE     = 5;
  localparam int POS_WIN1_WIDTH_SEL     = 4;
  localparam int POS_WIN0_EXTRA_WAIT    = 3;
  localparam int POS_WIN0_SHORT_BYTE    = 2;
  localparam int POS_WIN0_AUTO_SIZE     = 1;
  localparam int POS_WIN0_WIDTH_SEL     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // timing: isa-equivalent cycle, counted in system clocks
  localparam int CLK_PERIOD_PS   = 10000;
  localparam int ISA_PERIOD_PS   = 125000;
  localparam int ISA_CLKS        = (ISA_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STD_BYTE_ISA    = 6;   // standard 8-bit cycle
  localparam int SHORT_BYTE_ISA  = 3;   // shortened 8-bit cycle
  localparam int STD_WORD_ISA    = 3;   // standard 16-bit cycle
  localparam int EXTRA_WAIT_ISA  = 1;   // added wait state
  localparam int CNT_W           = 8;

  // cycle engine states
  typedef enum logic [1:0] {ST_IDLE, ST_CYCLE, ST_DONE} cyc_state_t;

endpackage

/* src/io_window_config.sv */
// i/o window registers and windowed host-to-card i/o cycle engine
`timescale 1ns/10ps
//
// Behaviour
// - window 1 extra-wait bit adds one isa wait state to 16-bit window 1 cycles only.
// - window 1 short-cycle bit cuts 8-bit window 1 cycles to three isa cycles only.
// - window 1 auto-size bit takes the width from the card's sizing pin.
// - window 1 width bit gives 8 bits at 0, 16 bits at 1, ignored under auto-size.
// - window 0 extra-wait bit adds one isa wait state to 16-bit window 0 cycles only.
// - window 0 short-cycle bit cuts 8-bit window 0 cycles to three isa cycles only.
// - window 0 auto-size bit takes the width from the card's sizing pin.
// - window 0 width bit gives 8 bits at 0, 16 bits at 1, ignored under auto-size.
// - each window holds a read/write start address low byte, reset to zero.
// - each window holds a read/write start address high byte, reset to zero.
// - each window holds a read/write end address low byte.
// - each window holds a read/write end address high byte, reset to zero.
// - a window whose enable bit is clear never claims a host i/o cycle.
module io_window_config
(
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_ack_o,
  // host i/o cycle request
  input  wire logic        io_req_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_write_i,
  output logic             io_ready_o,
  output logic             io_claim_o,
  output logic             io_miss_o,
  output logic             io_done_o,
  // card side
  input  wire logic        card_iois16_i,
  output logic             card_cyc_o,
  output logic      [15:0] card_addr_o,
  output logic             card_write_o,
  output logic             card_wide_o,
  output logic             card_win_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // inclusive range check of a 16-bit address
  function automatic logic in_window(input logic [15:0] addr,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
    in_window = (addr >= lo) && (addr <= hi);
  endfunction

  // cycle length in system clocks from width and timing bits
  function automatic logic [7:0] cycle_clks(input logic wide,
                                            input logic extra,
                                            input logic short_b);
    int isa;
    isa = 0;
    if (wide)
    begin
      isa = io_window_pkg::STD_WORD_ISA;
      if (extra)
      begin
        isa = isa + io_window_pkg::EXTRA_WAIT_ISA;
      end
    end
    else
    begin
      isa = short_b ? io_window_pkg::SHORT_BYTE_ISA : io_window_pkg::STD_BYTE_ISA;
    end
    cycle_clks = 8'(isa * io_window_pkg::ISA_CLKS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] enable_q;
  logic [7:0] enable_d;
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic [7:0] addr_q [0:7];
  logic [7:0] addr_d [0:7];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       ack_q;
  logic       ack_d;
  logic [7:0] rel_addr;

  // index of an address byte relative to window 0 start low
  assign rel_addr = reg_addr_i - io_window_pkg::OFF_WIN0_START_LOW;

  // next register values and read data
  always_comb
  begin
    enable_d  = enable_q;
    control_d = control_q;
    addr_d    = addr_q;
    rdata_d   = rdata_q;
    ack_d     = reg_wr_i | reg_rd_i;
    if (reg_wr_i)
    begin
      if (reg_addr_i == io_window_pkg::OFF_WINDOW_ENABLE)
      begin
        enable_d = reg_wdata_i;
        enable_d[io_window_pkg::POS_ENABLE_RSVD] = 1'b0;
      end
      else if (reg_addr_i == io_window_pkg::OFF_CYCLE_CONTROL)
      begin
        control_d = reg_wdata_i;
      end
      else if (reg_addr_i >= io_window_pkg::OFF_WIN0_START_LOW &&
               reg_addr_i <= io_window_pkg::OFF_WIN1_END_HI)
      begin
        addr_d[rel_addr[2:0]] = reg_wdata_i;
      end
    end
    if (reg_rd_i)
    begin
      if (reg_addr_i == io_window_pkg::OFF_WINDOW_ENABLE)
      begin
        rdata_d = enable_q;
      end
      else if (reg_addr_i == io_window_pkg::OFF_CYCLE_CONTROL)
      begin
        rdata_d = control_q;
      end
      else if (reg_addr_i >= io_window_pkg::OFF_WIN0_START_LOW &&
               reg_addr_i <= io_window_pkg::OFF_WIN1_END_HI)
      begin
        rdata_d = addr_q[rel_addr[2:0]];
      end
      else
      begin
        rdata_d = 8'h00;  // unmapped
      end
    end
  end

  // register storage
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      enable_q  <= io_window_pkg::RST_WINDOW_ENABLE;
      control_q <= io_window_pkg::RST_CYCLE_CONTROL;
      for (int i = 0; i < 8; i++)
      begin
        addr_q[i] <= io_window_pkg::RST_ADDR_BYTE;
      end
      rdata_q   <= 8'h00;
      ack_q     <= 1'b0;
    end
    else
    begin
      enable_q  <= enable_d;
      control_q <= control_d;
      addr_q    <= addr_d;
      rdata_q   <= rdata_d;
      ack_q     <= ack_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_ack_o   = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // window decode

  logic [15:0] win0_start;
  logic [15:0] win0_end;
  logic [15:0] win1_start;
  logic [15:0] win1_end;
  logic        hit0;
  logic        hit1;

  // 16-bit ranges assembled from the byte registers
  assign win0_start = {addr_q[1], addr_q[0]};
  assign win0_end   = {addr_q[3], addr_q[2]};
  assign win1_start = {addr_q[5], addr_q[4]};
  assign win1_end   = {addr_q[7], addr_q[6]};

  // enable gates the range match
  assign hit0 = enable_q[io_window_pkg::POS_IO_WINDOW_ZERO_ON] &&
                in_window(io_addr_i, win0_start, win0_end);
  assign hit1 = enable_q[io_window_pkg::POS_IO_WINDOW_ONE_ON] &&
                in_window(io_addr_i, win1_start, win1_end);

  ////////////////////////////////////////////////////////////////////////////
  // card sizing pin synchroniser

  logic iois16_meta_q;
  logic iois16_sync_q;

  // two flops before any use
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      iois16_meta_q <= 1'b0;
      iois16_sync_q <= 1'b0;
    end
    else
    begin
      iois16_meta_q <= card_iois16_i;
      iois16_sync_q <= iois16_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-window width and length

  logic       wide0;
  logic       wide1;
  logic [7:0] len0;
  logic [7:0] len1;

  // auto-size picks the card pin, else the width bit
  assign wide0 = control_q[io_window_pkg::POS_WIN0_AUTO_SIZE] ? iois16_sync_q :
                 control_q[io_window_pkg::POS_WIN0_WIDTH_SEL];
  assign wide1 = control_q[io_window_pkg::POS_WIN1_AUTO_SIZE] ? iois16_sync_q :
                 control_q[io_window_pkg::POS_WIN1_WIDTH_SEL];

  // wait bits act on their own width only
  assign len0 = cycle_clks(wide0, control_q[io_window_pkg::POS_WIN0_EXTRA_WAIT],
                           control_q[io_window_pkg::POS_WIN0_SHORT_BYTE]);
  assign len1 = cycle_clks(wide1, control_q[io_window_pkg::POS_WIN1_EXTRA_WAIT],
                           control_q[io_window_pkg::POS_WIN1_SHORT_BYTE]);

  ////////////////////////////////////////////////////////////////////////////
  // cycle engine

  io_window_pkg::cyc_state_t state_q;
  io_window_pkg::cyc_state_t state_d;
  logic [7:0]  cnt_q;
  logic [7:0]  cnt_d;
  logic [15:0] caddr_q;
  logic [15:0] caddr_d;
  logic        cwrite_q;
  logic        cwrite_d;
  logic        cwide_q;
  logic        cwide_d;
  logic        cwin_q;
  logic        cwin_d;
  logic        claim_q;
  logic        claim_d;
  logic        miss_q;
  logic        miss_d;
  logic        done_q;
  logic        done_d;

  // window 0 wins when both ranges overlap
  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    caddr_d  = caddr_q;
    cwrite_d = cwrite_q;
    cwide_d  = cwide_q;
    cwin_d   = cwin_q;
    claim_d  = 1'b0;
    miss_d   = 1'b0;
    done_d   = 1'b0;
    unique case (state_q)
      io_window_pkg::ST_IDLE:
      begin
        if (io_req_i)
        begin
          if (hit0 || hit1)
          begin
            claim_d  = 1'b1;
            caddr_d  = io_addr_i;
            cwrite_d = io_write_i;
            cwin_d   = !hit0;
            cwide_d  = hit0 ? wide0 : wide1;
            cnt_d    = hit0 ? len0 : len1;
            state_d  = io_window_pkg::ST_CYCLE;
          end
          else
          begin
            miss_d = 1'b1;
          end
        end
      end
      io_window_pkg::ST_CYCLE:
      begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01)
        begin
          done_d  = 1'b1;
          state_d = io_window_pkg::ST_DONE;
        end
      end
      io_window_pkg::ST_DONE:
      begin
        state_d = io_window_pkg::ST_IDLE;
      end
    endcase
  end

  // cycle state registers
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state_q  <= io_window_pkg::ST_IDLE;
      cnt_q    <= 8'h00;
      caddr_q  <= 16'h0000;
      cwrite_q <= 1'b0;
      cwide_q  <= 1'b0;
      cwin_q   <= 1'b0;
      claim_q  <= 1'b0;
      miss_q   <= 1'b0;
      done_q   <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      caddr_q  <= caddr_d;
      cwrite_q <= cwrite_d;
      cwide_q  <= cwide_d;
      cwin_q   <= cwin_d;
      claim_q  <= claim_d;
      miss_q   <= miss_d;
      done_q   <= done_d;
    end
  end

  // outputs
  assign io_ready_o   = (state_q == io_window_pkg::ST_IDLE);
  assign io_claim_o   = claim_q;
  assign io_miss_o    = miss_q;
  assign io_done_o    = done_q;
  assign card_cyc_o   = (state_q == io_window_pkg::ST_CYCLE);
  assign card_addr_o  = caddr_q;
  assign card_write_o = cwrite_q;
  assign card_wide_o  = cwide_q;
  assign card_win_o   = cwin_q;

endmodule

/* testbench/io_window_config_assertions.sv */
// checker for the i/o window configuration block
`timescale 1ns/10ps
module io_window_config_assertions
(
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_ack_o,
  input wire logic        io_req_i,
  input wire logic        io_ready_o,
  input wire logic        io_claim_o,
  input wire logic        io_miss_o,
  input wire logic        io_done_o,
  input wire logic        card_iois16_i,
  input wire logic        card_cyc_o,
  input wire logic        card_wide_o,
  input wire logic        card_win_o
);
  localparam int C = io_window_pkg::ISA_CLKS;
  logic [7:0] ctl_q;
  logic [7:0] en_q;
  logic [7:0] len_q;
  logic [3:0] nib;

  ////////////////////////////////////////////////////////////////////////////
  // shadow of control and enable bytes, length of the running card cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ctl_q <= 8'h00;
      en_q  <= 8'h00;
    end
    else if (reg_wr_i && reg_addr_i == io_window_pkg::OFF_CYCLE_CONTROL)
      ctl_q <= reg_wdata_i;
    else if (reg_wr_i && reg_addr_i == io_window_pkg::OFF_WINDOW_ENABLE)
      en_q <= reg_wdata_i;
  end
  always_ff @(posedge clk_sys_i)
    len_q <= card_cyc_o ? len_q + 8'h01 : 8'h00;
  // control nibble of the window in use
  assign nib = card_win_o ? ctl_q[7:4] : ctl_q[3:0];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  chk_reg_ack: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
    else $error("register ack missing");
  chk_take_answer: assert property (io_req_i && io_ready_o |=> io_claim_o != io_miss_o)
    else $error("request not answered once");
  chk_claim_enabled: assert property (io_claim_o |-> (card_win_o ? en_q[7] : en_q[6]))
    else $error("disabled window claimed");
  chk_miss_idle: assert property (io_miss_o |-> io_ready_o && !card_cyc_o)
    else $error("miss started a card cycle");
  chk_byte_std: assert property ($fell(card_cyc_o) && !card_wide_o && !nib[2] |-> len_q == C * 6)
    else $error("standard byte cycle length");
  chk_byte_short: assert property ($fell(card_cyc_o) && !card_wide_o && nib[2] |-> len_q == C * 3)
    else $error("short byte cycle length");
  chk_word_std: assert property ($fell(card_cyc_o) && card_wide_o && !nib[3] |-> len_q == C * 3)
    else $error("standard word cycle length");
  chk_word_extra: assert property ($fell(card_cyc_o) && card_wide_o && nib[3] |-> len_q == C * 4)
    else $error("extended word cycle length");
  chk_done_ready: assert property ($fell(card_cyc_o) |-> io_done_o ##1 io_ready_o)
    else $error("done or ready missing at cycle end");
  chk_fixed_width: assert property (io_claim_o && !nib[1] |-> card_wide_o == nib[0])
    else $error("fixed width wrong");
  chk_auto_width: assert property (io_claim_o && nib[1] |-> card_wide_o == $past(card_iois16_i, 3))
    else $error("auto width wrong");
  // main scenarios
  cover property (io_miss_o);
  cover property ($fell(card_cyc_o) && card_wide_o && nib[3]);
  cover property (io_claim_o && nib[1]);
endmodule

/* testbench/pc_card_model.sv */
// behavioural pc card: drives its sizing pin from the selected mode
`timescale 1ns/10ps
module pc_card_model
(
  input  wire logic clk_sys_i,
  input  wire logic wide_mode_i,
  output logic      card_iois16_o
);
  // sizing pin follows the card's decode mode one clock later
  always_ff @(posedge clk_sys_i)
    card_iois16_o <= wide_mode_i;
endmodule

/* testbench/io_window_config_tb.sv */
// self-checking bench for the i/o window configuration block
`timescale 1ns/10ps
module io_window_config_tb;
  logic        clk_sys_i, srst_i, reg_wr_i, reg_rd_i, reg_ack_o, io_req_i, io_write_i, wide_mode;
  logic        io_ready_o, io_claim_o, io_miss_o, io_done_o, card_iois16_i;
  logic        card_cyc_o, card_write_o, card_wide_o, card_win_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, m [16];
  logic [15:0] io_addr_i, card_addr_o;
  int          mismatches, comparisons;

  io_window_config dut
  (
    .clk_sys_i     (clk_sys_i),
    .srst_i        (srst_i),
    .reg_addr_i    (reg_addr_i),
    .reg_wr_i      (reg_wr_i),
    .reg_rd_i      (reg_rd_i),
    .reg_wdata_i   (reg_wdata_i),
    .reg_rdata_o   (reg_rdata_o),
    .reg_ack_o     (reg_ack_o),
    .io_req_i      (io_req_i),
    .io_addr_i     (io_addr_i),
    .io_write_i    (io_write_i),
    .io_ready_o    (io_ready_o),
    .io_claim_o    (io_claim_o),
    .io_miss_o     (io_miss_o),
    .io_done_o     (io_done_o),
    .card_iois16_i (card_iois16_i),
    .card_cyc_o    (card_cyc_o),
    .card_addr_o   (card_addr_o),
    .card_write_o  (card_write_o),
    .card_wide_o   (card_wide_o),
    .card_win_o    (card_win_o)
  );
  pc_card_model card (.clk_sys_i, .wide_mode_i(wide_mode), .card_iois16_o(card_iois16_i));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // register write, shadowed for expectations
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    if (a >= 8'h06 && a <= 8'h0f)
      m[a[3:0]] = (a == 8'h06) ? (d & 8'hdf) : d;
    @(posedge clk_sys_i);
    #1 reg_wr_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  // register read against the shadow, unmapped reads zero
  task automatic rd(input logic [7:0] a);
    logic [7:0] want;
    want = (a >= 8'h06 && a <= 8'h0f) ? m[a[3:0]] : 8'h00;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clk_sys_i);
    #1 reg_rd_i = 1'b0;
    check(16'(reg_ack_o), 16'h0001);
    check({8'h00, reg_rdata_o}, {8'h00, want});
    @(posedge clk_sys_i);
    #1;
  endtask
  // one host i/o request with predicted window, width and length
  task automatic io(input logic [15:0] a);
    logic h0, h1, w, wide;
    logic [3:0] nb;
    int k, len;
    h0 = m[6][6] && a >= {m[9], m[8]} && a <= {m[11], m[10]};
    h1 = m[6][7] && a >= {m[13], m[12]} && a <= {m[15], m[14]};
    w = !h0;
    nb = w ? m[7][7:4] : m[7][3:0];
    wide = nb[1] ? wide_mode : nb[0];
    len = io_window_pkg::ISA_CLKS * (wide ? (nb[3] ? 4 : 3) : (nb[2] ? 3 : 6));
    io_addr_i = a;
    io_write_i = 1'($urandom);
    io_req_i = 1'b1;
    @(posedge clk_sys_i);
    #1 io_req_i = 1'b0;
    check(16'(io_claim_o), 16'(h0 || h1));
    check(16'(io_miss_o), 16'(!(h0 || h1)));
    if (h0 || h1)
    begin
      check(card_addr_o, a);
      check(16'(card_write_o), 16'(io_write_i));
      check(16'(card_win_o), 16'(w));
      check(16'(card_wide_o), 16'(wide));
      k = 0;
      while (io_done_o !== 1'b1 && k < 200)
      begin
        @(posedge clk_sys_i);
        #1 k++;
      end
      check(16'(k), 16'(len));
    end
    // let an edge pass so the engine is back in idle before the next request
    @(posedge clk_sys_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] cfg [8];
    int i, j;
    cfg = '{8'h00, 8'h03, 8'h0f, 8'h03, 8'h10, 8'h03, 8'h1f, 8'h03};
    {srst_i, reg_wr_i, reg_rd_i, io_req_i, io_write_i, wide_mode} = 6'h20;
    {reg_addr_i, reg_wdata_i, io_addr_i} = 32'h0;
    mismatches = 0;
    comparisons = 0;
    foreach (m[i]) m[i] = 8'h00;
    i = $urandom(32'h37b8);
    repeat (3) @(posedge clk_sys_i);
    #1 srst_i = 1'b0;
    for (i = 6; i < 16; i++) rd(8'(i));
    rd(8'h20);
    $display("reset values done");
    for (i = 6; i < 16; i++) wr(8'(i), 8'($urandom));
    wr(8'h20, 8'hff);
    for (i = 6; i < 16; i++) rd(8'(i));
    rd(8'h20);
    $display("readback done");
    wr(8'h06, 8'h00);
    for (i = 0; i < 8; i++) wr(8'h08 + 8'(i), cfg[i]);
    io(16'h0300);
    io(16'h0315);
    wr(8'h06, 8'h40);
    io(16'h0310);
    io(16'h0300);
    wr(8'h06, 8'h80);
    io(16'h030f);
    io(16'h0310);
    io(16'h0320);
    $display("disabled windows done");
    wr(8'h06, 8'hc0);
    for (i = 0; i < 24; i++)
    begin
      wide_mode = 1'($urandom);
      wr(8'h07, (i < 16) ? {4'(i), 4'(i)} : 8'($urandom));
      #30;
      foreach (cfg[j]) io(j == 7 ? 16'h0300 + 16'($urandom % 32) : 16'h02ff + 16'(j * 16 % 34));
    end
    $display("window cycles done");
    results();
  end

  // watchdog against a hung handshake
  initial
  begin
    #500us;
    mismatches++;
    results();
  end
endmodule

bind io_window_config io_window_config_assertions chk
(
  .clk_sys_i     (clk_sys_i),
  .srst_i        (srst_i),
  .reg_addr_i    (reg_addr_i),
  .reg_wr_i      (reg_wr_i),
  .reg_rd_i      (reg_rd_i),
  .reg_wdata_i   (reg_wdata_i),
  .reg_ack_o     (reg_ack_o),
  .io_req_i      (io_req_i),
  .io_ready_o    (io_ready_o),
  .io_claim_o    (io_claim_o),
  .io_miss_o     (io_miss_o),
  .io_done_o     (io_done_o),
  .card_iois16_i (card_iois16_i),
  .card_cyc_o    (card_cyc_o),
  .card_wide_o   (card_wide_o),
  .card_win_o    (card_win_o)
);
